// >>> hdl/sofp_top.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - with invert clear, the output turns on once the field rises above the operate threshold.
// - with invert clear, the output turns off once the field falls below the release threshold.
// - with invert set, the output turns on when the field drops below the release threshold.
// - programming happens only through serial pulses on the supply, decoded to pick and change a field.
// - every supply pulse is classed as high, mid or low.
// - a try value applies at once, is temporary and is lost on a supply cycle.
// - blow mode makes a value permanent in fuses, and the lock is set only this way.
// - read mode shows whether each fuse bit is blown, one bit at a time.
// - once the lock fuse is blown, no parameter register is reachable; only the fuse check stays.
// - programming starts only after a deliberate multi-level key, so noise cannot change fields.
// - a key is one high, one mid, then a register-unique mix of high and mid pulses.
// - eleven mid pulses then one high pulse after the key select blow or read mode.
// - in try mode the code becomes 1 at the key's final high pulse, then rises by one per mid pulse, wrapping to 0 after the register's maximum code.
// - fall time sits in bits 1:0 and invert in bit 2 of one register, set by one combined code.
module sofp_top
  import sofp_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // supply level and field comparators (asynchronous)
  input  wire logic        high_pulse_level,
  input  wire logic        mid_pulse_level,
  input  wire logic        above_operate,
  input  wire logic        below_release,
  // switch output and analog trim
  output logic             switch_out,
  output logic [7:0]       threshold_magnitude_select,
  output logic             threshold_sign_select,
  output logic [1:0]       fall_time_select
);

  typedef struct packed {
    sofp_state_t st;
    logic [2:0]  key_cnt;
    logic [2:0]  reg_id;
    logic [7:0]  code;
    logic [3:0]  mid_run;
    logic        try_th;
    logic [7:0]  try_mag;
    logic        try_sign;
    logic        try_fp;
    logic [2:0]  try_fpv;
    logic [12:0] fuse;
    logic        field_high;
    logic        switch_out;
    logic [7:0]  mag_out;
    logic        sign_out;
    logic [1:0]  fall_out;
    logic        inv;
    logic        prog_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sofp_top_s_t;

  sofp_top_s_t s_ff;
  sofp_top_s_t nxt_s;

  logic [3:0] pins_s;
  logic       evt;
  logic       evt_high;
  logic       above_s;
  logic       below_s;
  logic       locked;
  logic [7:0] code_max;
  logic [3:0] fbase;
  logic [3:0] fwidth;
  logic [7:0] mag_eff;
  logic       sign_eff;
  logic [2:0] fpv_eff;
  logic       wr_acc;

  // ----------------------------------------------------------------
  // pin synchronisers and pulse classifier
  // ----------------------------------------------------------------
  sofp_sync #(
    .W (4)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({high_pulse_level, mid_pulse_level, above_operate, below_release}),
    .q       (pins_s)
  );

  sofp_pulse_qual u_qual (
    .pclk        (pclk),
    .presetn     (presetn),
    .lvl_high    (pins_s[3]),
    .lvl_mid     (pins_s[2]),
    .evt_ff      (evt),
    .evt_high_ff (evt_high)
  );

  assign above_s = pins_s[1];
  assign below_s = pins_s[0];
  assign locked  = s_ff.fuse[SOFP_FB_LOCK];
  assign wr_acc  = psel && penable && s_ff.pready && pwrite;

  // ----------------------------------------------------------------
  // per-register code limit and fuse field position
  // ----------------------------------------------------------------
  always_comb begin
    code_max = SOFP_CODE_MAX_LK;
    fbase    = SOFP_FB_LOCK;
    fwidth   = SOFP_FW_LK;
    if (s_ff.reg_id < SOFP_ID_FALLPOL) begin
      code_max = SOFP_CODE_MAX_TH;
      fbase    = SOFP_FB_MAG;
      fwidth   = SOFP_FW_TH;
    end else if (s_ff.reg_id == SOFP_ID_FALLPOL) begin
      code_max = SOFP_CODE_MAX_FP;
      fbase    = SOFP_FB_FALL;
      fwidth   = SOFP_FW_FP;
    end
  end

  // ----------------------------------------------------------------
  // next state: apb, key decoder, trim and switch output
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    // apb: data captured in setup, zero wait states in access
    nxt_s.pready  = 1'b0;
    nxt_s.pslverr = 1'b0;
    if (psel && !penable) begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = 32'h0000_0000;
      unique case (paddr)
        SOFP_ADDR_CTRL:   nxt_s.prdata = {31'h0000_0000, s_ff.prog_en};
        SOFP_ADDR_STATUS: nxt_s.prdata = {16'h0000, s_ff.code, 1'b0, locked, s_ff.try_fp, s_ff.try_th,
                                          1'b0, s_ff.st};
        SOFP_ADDR_FUSE:   nxt_s.prdata = {19'h0_0000, s_ff.fuse};
        SOFP_ADDR_CONFIG: nxt_s.prdata = {19'h0_0000, s_ff.switch_out, s_ff.inv, s_ff.fall_out,
                                          s_ff.sign_out, s_ff.mag_out};
        default:          nxt_s.pslverr = 1'b1;
      endcase
    end
    if (wr_acc && paddr == SOFP_ADDR_CTRL) begin
      nxt_s.prog_en = pwdata[0];
    end

    // supply pulse decoder; an unexpected pulse after the first key pulse parks it until reset or until the enable is cleared
    if (evt && s_ff.prog_en) begin
      unique case (s_ff.st)
        ST_IDLE: begin
          if (evt_high) begin
            nxt_s.st      = ST_KEY;
            nxt_s.key_cnt = 3'h1;
            nxt_s.reg_id  = 3'h0;
          end
        end
        ST_KEY: begin
          nxt_s.key_cnt = s_ff.key_cnt + 3'h1;
          if (s_ff.key_cnt == 3'h1) begin
            if (evt_high) nxt_s.st = ST_DEAD;
          end else if (s_ff.key_cnt < SOFP_KEY_LAST) begin
            nxt_s.reg_id = {s_ff.reg_id[1:0], evt_high};
          end else if (!evt_high || s_ff.reg_id > SOFP_ID_READ) begin
            nxt_s.st = ST_DEAD;
          end else if (locked && s_ff.reg_id != SOFP_ID_READ) begin
            nxt_s.st = ST_DEAD;
          end else begin
            nxt_s.st      = ST_TRY;
            nxt_s.code    = 8'h01;
            nxt_s.mid_run = 4'h0;
          end
        end
        ST_TRY: begin
          if (!evt_high) begin
            nxt_s.code    = (s_ff.code == code_max) ? 8'h00 : s_ff.code + 8'h01;
            nxt_s.mid_run = (s_ff.mid_run == 4'hF) ? 4'hF : s_ff.mid_run + 4'h1;
          end else if (s_ff.mid_run == SOFP_MODE_RUN) begin
            nxt_s.st   = (s_ff.reg_id == SOFP_ID_READ) ? ST_READ : ST_BLOW;
            nxt_s.code = 8'h00;
          end else begin
            nxt_s.st = ST_DEAD;
          end
        end
        ST_BLOW: begin
          if (!evt_high) begin
            nxt_s.code = s_ff.code + 8'h01;
          end else if (s_ff.code < {4'h0, fwidth}) begin
            nxt_s.fuse[fbase + s_ff.code[3:0]] = 1'b1;
          end
        end
        ST_READ: begin
          if (!evt_high) begin
            nxt_s.code = s_ff.code + 8'h01;
          end
        end
        ST_DEAD: begin
        end
      endcase
    end
    // clearing the enable abandons any sequence; fuses survive, unlike a power cycle
    if (wr_acc && paddr == SOFP_ADDR_CTRL && !pwdata[0]) begin
      nxt_s.st = ST_IDLE;
    end

    // try values take effect at once; only power-on reset clears them
    if (nxt_s.st == ST_TRY && (s_ff.st != ST_TRY || nxt_s.code != s_ff.code)) begin
      if (s_ff.reg_id < SOFP_ID_FALLPOL) begin
        nxt_s.try_th   = 1'b1;
        nxt_s.try_mag  = s_ff.reg_id[0] ? ~nxt_s.code : nxt_s.code;
        nxt_s.try_sign = s_ff.reg_id[1];
      end else if (s_ff.reg_id == SOFP_ID_FALLPOL) begin
        nxt_s.try_fp  = 1'b1;
        nxt_s.try_fpv = nxt_s.code[2:0];
      end
    end

    // effective trim: try overrides fuses
    mag_eff  = s_ff.try_th ? s_ff.try_mag : s_ff.fuse[SOFP_FB_MAG +: 8];
    sign_eff = s_ff.try_th ? s_ff.try_sign : s_ff.fuse[SOFP_FB_SIGN];
    fpv_eff  = s_ff.try_fp ? s_ff.try_fpv : s_ff.fuse[SOFP_FB_FALL +: 3];
    nxt_s.mag_out  = mag_eff;
    nxt_s.sign_out = sign_eff;
    nxt_s.fall_out = fpv_eff[1:0];
    nxt_s.inv      = fpv_eff[2];

    // hysteresis: set above operate, clear below release
    if (above_s) begin
      nxt_s.field_high = 1'b1;
    end else if (below_s) begin
      nxt_s.field_high = 1'b0;
    end
    // read mode borrows the output to show the addressed fuse
    if (s_ff.st == ST_READ) begin
      nxt_s.switch_out = (s_ff.code < 8'(SOFP_FUSE_W)) ? s_ff.fuse[s_ff.code[3:0]] : 1'b0;
    end else begin
      nxt_s.switch_out = nxt_s.field_high ^ s_ff.inv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{ST_IDLE, 3'h0, 3'h0, 8'h00, 4'h0, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0, SOFP_RST_FUSE,
                1'b0, 1'b0, 8'h00, 1'b0, 2'h0, 1'b0, SOFP_RST_PROG_EN, 32'h0000_0000, 1'b0, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata                     = s_ff.prdata;
  assign pready                     = s_ff.pready;
  assign pslverr                    = s_ff.pslverr;
  assign switch_out                 = s_ff.switch_out;
  assign threshold_magnitude_select = s_ff.mag_out;
  assign threshold_sign_select      = s_ff.sign_out;
  assign fall_time_select           = s_ff.fall_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  out_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    above_s && !s_ff.inv && s_ff.st != ST_READ && $stable(s_ff.inv) |=> switch_out)
    else $error("output not on above operate threshold");

  out_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    below_s && !above_s && !s_ff.inv && s_ff.st != ST_READ |=> !switch_out)
    else $error("output not off below release threshold");

  inv_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    above_s && s_ff.inv && s_ff.st != ST_READ |=> !switch_out)
    else $error("inverted output not off above operate threshold");

  inv_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    below_s && !above_s && s_ff.inv && s_ff.st != ST_READ |=> switch_out)
    else $error("inverted output not on below release threshold");

  try_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.st == ST_KEY && $past(s_ff.st) == ST_KEY ##0 (evt && s_ff.prog_en && s_ff.key_cnt == SOFP_KEY_LAST)
    ##1 s_ff.st == ST_TRY |-> s_ff.code == 8'h01)
    else $error("try code not 1 after key");

  mode_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.st == ST_TRY ##1 (s_ff.st == ST_BLOW || s_ff.st == ST_READ)
    |-> $past(s_ff.mid_run) == SOFP_MODE_RUN && s_ff.code == 8'h00)
    else $error("mode entered without eleven mid pulses");

  lock_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    locked && s_ff.st == ST_KEY |=> s_ff.st != ST_TRY || s_ff.reg_id == SOFP_ID_READ)
    else $error("register reached while locked");

  fuse_only_blow_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.fuse != $past(s_ff.fuse) |-> $past(s_ff.st) == ST_BLOW && $past(evt_high))
    else $error("fuse changed outside blow mode");

  read_show_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.st == ST_READ && $stable(s_ff.st) && $stable(s_ff.code) && s_ff.code < 8'(SOFP_FUSE_W)
    |=> switch_out == $past(s_ff.fuse[s_ff.code[3:0]]))
    else $error("read mode output does not show fuse bit");

  try_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.try_fp |=> s_ff.inv == $past(s_ff.try_fpv[2]) && fall_time_select == $past(s_ff.try_fpv[1:0]))
    else $error("combined fall and invert code misplaced");

endmodule

// >>> hdl/sofp_pkg.sv
package sofp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SOFP_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] SOFP_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SOFP_ADDR_FUSE   = 8'h08;
  localparam logic [7:0] SOFP_ADDR_CONFIG = 8'h0C;
  localparam logic       SOFP_RST_PROG_EN = 1'b1;

  // ----------------------------------------------------------------
  // pulse qualification timing
  // ----------------------------------------------------------------
  localparam int         SOFP_CLK_PERIOD_NS = 10;
  localparam int         SOFP_QUAL_TIME_NS  = 2000;
  localparam logic [7:0] SOFP_QUAL_CYCLES   =
    8'((SOFP_QUAL_TIME_NS + SOFP_CLK_PERIOD_NS - 1) / SOFP_CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // key decoding
  // ----------------------------------------------------------------
  localparam logic [2:0] SOFP_KEY_LAST    = 3'h5;  // key pulses before its final high pulse
  localparam logic [3:0] SOFP_MODE_RUN    = 4'hB;  // mid pulses before the mode high pulse
  localparam logic [2:0] SOFP_ID_FALLPOL  = 3'h4;
  localparam logic [2:0] SOFP_ID_LOCK     = 3'h5;
  localparam logic [2:0] SOFP_ID_READ     = 3'h6;
  localparam logic [7:0] SOFP_CODE_MAX_TH = 8'hFF;
  localparam logic [7:0] SOFP_CODE_MAX_FP = 8'h07;
  localparam logic [7:0] SOFP_CODE_MAX_LK = 8'h01;

  // ----------------------------------------------------------------
  // fuse word layout
  // ----------------------------------------------------------------
  localparam int         SOFP_FUSE_W     = 13;
  localparam logic [3:0] SOFP_FB_MAG     = 4'h0;  // 8 magnitude bits
  localparam logic [3:0] SOFP_FB_SIGN    = 4'h8;
  localparam logic [3:0] SOFP_FB_FALL    = 4'h9;  // fall time 1:0, invert at +2
  localparam logic [3:0] SOFP_FB_LOCK    = 4'hC;
  localparam logic [3:0] SOFP_FW_TH      = 4'h9;
  localparam logic [3:0] SOFP_FW_FP      = 4'h3;
  localparam logic [3:0] SOFP_FW_LK      = 4'h1;
  localparam logic [12:0] SOFP_RST_FUSE  = 13'h0000;

  typedef enum logic [2:0] {ST_IDLE, ST_KEY, ST_TRY, ST_BLOW, ST_READ, ST_DEAD} sofp_state_t;
  typedef enum logic [1:0] {LV_LOW, LV_MID, LV_HIGH} sofp_level_t;

endpackage

// >>> hdl/sofp_sync.sv
`timescale 1ns/10ps
module sofp_sync
  import sofp_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sofp_sync_s_t;

  sofp_sync_s_t s_ff;
  sofp_sync_s_t nxt_s;

  // first stage feeds only the second stage
  always_comb begin
    nxt_s.meta   = d;
    nxt_s.stable = s_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.stable;

endmodule

// >>> hdl/sofp_pulse_qual.sv
`timescale 1ns/10ps
module sofp_pulse_qual
  import sofp_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // synchronised supply level comparators
  input  wire logic lvl_high,
  input  wire logic lvl_mid,
  // one-cycle pulse end event and its kind
  output logic      evt_ff,
  output logic      evt_high_ff
);

  typedef struct packed {
    sofp_level_t cand;
    logic [7:0]  cnt;
    sofp_level_t stable;
    logic        evt;
    logic        evt_high;
  } sofp_qual_s_t;

  sofp_qual_s_t s_ff;
  sofp_qual_s_t nxt_s;
  sofp_level_t  raw;

  // ----------------------------------------------------------------
  // level classification and qualification
  // ----------------------------------------------------------------
  // a level must hold a full window before it counts, so supply glitches vanish
  always_comb begin
    raw = lvl_high ? LV_HIGH : (lvl_mid ? LV_MID : LV_LOW);
    nxt_s = s_ff;
    nxt_s.evt      = 1'b0;
    nxt_s.evt_high = 1'b0;
    if (raw != s_ff.cand) begin
      nxt_s.cand = raw;
      nxt_s.cnt  = 8'h00;
    end else if (s_ff.cnt < SOFP_QUAL_CYCLES - 8'h01) begin
      nxt_s.cnt = s_ff.cnt + 8'h01;
    end else if (s_ff.stable != s_ff.cand) begin
      nxt_s.stable = s_ff.cand;
      // event on the qualified falling edge back to the low level
      if (s_ff.cand == LV_LOW) begin
        nxt_s.evt      = 1'b1;
        nxt_s.evt_high = (s_ff.stable == LV_HIGH);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{LV_LOW, 8'h00, LV_LOW, 1'b0, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign evt_ff      = s_ff.evt;
  assign evt_high_ff = s_ff.evt_high;

  // an event needs the low level to have been seen for the whole window
  qual_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt_ff |-> $past(s_ff.cnt) == SOFP_QUAL_CYCLES - 8'h01 && s_ff.cand == LV_LOW)
    else $error("pulse event without a full qualification window");

endmodule

// >>> verif/sofp_prog_model.sv
`timescale 1ns/10ps
module sofp_prog_model
  import sofp_pkg::*;
#(
  parameter int ACTIVE_CYC = 220,
  parameter int LOW_CYC    = 220
) (
  // clock
  input  wire logic pclk,
  // supply level comparators seen by the device
  output logic      high_pulse_level,
  output logic      mid_pulse_level
);
  // ----------------------------------------------------------------
  // supply pulses
  // ----------------------------------------------------------------
  // the supply rests at the low level between pulses, never undriven
  initial begin
    high_pulse_level = 1'b0;
    mid_pulse_level  = 1'b0;
  end

  // one pulse then a low gap; a short width lets a scenario send a glitch
  task automatic pulse(input sofp_level_t lvl, input int width = ACTIVE_CYC);
    @(posedge pclk);
    high_pulse_level <= (lvl == LV_HIGH);
    mid_pulse_level  <= (lvl != LV_LOW);
    repeat (width) @(posedge pclk);
    high_pulse_level <= 1'b0;
    mid_pulse_level  <= 1'b0;
    repeat (LOW_CYC) @(posedge pclk);
  endtask

  // register key: high, mid, three id bits msb first (high is one), high
  task automatic key(input logic [2:0] id);
    pulse(LV_HIGH);
    pulse(LV_MID);
    for (int i = 2; i >= 0; i--) begin
      pulse(id[i] ? LV_HIGH : LV_MID);
    end
    pulse(LV_HIGH);
  endtask

  // mode suffix; a count other than eleven is a deliberate fault
  task automatic mode(input int n);
    repeat (n) pulse(LV_MID);
    pulse(LV_HIGH);
  endtask
endmodule

// >>> verif/switch_output_and_fuse_programming_tb_top.sv
`timescale 1ns/10ps
module switch_output_and_fuse_programming_tb_top
  import sofp_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hi_lvl;
  logic        mid_lvl;
  logic        above;
  logic        below;
  logic        switch_out;
  logic [7:0]  mag;
  logic        sign;
  logic [1:0]  fall;
  int          err_count = 0;
  int          check_count = 0;

  // 100 MHz
  always #5 pclk = ~pclk;

  sofp_top sofp_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_pulse_level(hi_lvl), .mid_pulse_level(mid_lvl), .above_operate(above),
    .below_release(below), .switch_out(switch_out), .threshold_magnitude_select(mag),
    .threshold_sign_select(sign), .fall_time_select(fall)
  );

  sofp_prog_model sofp_prog_model_i (
    .pclk(pclk), .high_pulse_level(hi_lvl), .mid_pulse_level(mid_lvl)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb transfer; the wait for pready is bounded so a dead slave ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      err_count++;
      $display("apb answer never came");
      print_verdict();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd & m, e);
  endtask

  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // field comparators pass two sync flops and a state flop, so allow six edges
  task automatic set_field(input logic a, input logic b);
    @(posedge pclk);
    above <= a;
    below <= b;
    repeat (6) @(posedge pclk);
  endtask

  // dropping and restoring the enable returns the decoder to idle, fuses kept
  task automatic restart();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, SOFP_ADDR_CTRL, 32'h0, rd, err);
    apb(1'b1, SOFP_ADDR_CTRL, 32'h1, rd, err);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] rd;
    logic        err;
    rd_chk(SOFP_ADDR_CTRL, 32'h1, 32'h1);
    rd_chk(SOFP_ADDR_STATUS, 32'hFF7F, 32'h0);
    apb(1'b1, SOFP_ADDR_FUSE, 32'h1FFF, rd, err);
    rd_chk(SOFP_ADDR_FUSE, 32'h1FFF, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    $display("done: register reset values");
  endtask

  task automatic t_out();
    set_field(1'b1, 1'b0);
    chk(32'(switch_out), 32'h1);
    set_field(1'b0, 1'b0);
    chk(32'(switch_out), 32'h1);
    set_field(1'b0, 1'b1);
    chk(32'(switch_out), 32'h0);
    $display("done: plain output");
  endtask

  task automatic t_inv();
    reset_dut();
    sofp_prog_model_i.key(SOFP_ID_FALLPOL);
    chk(32'(fall), 32'h1);
    rd_chk(SOFP_ADDR_STATUS, 32'hFF07, 32'h0102);
    repeat (3) sofp_prog_model_i.pulse(LV_MID);
    rd_chk(SOFP_ADDR_CONFIG, 32'h0E00, 32'h0800);
    chk(32'(switch_out), 32'h1);
    set_field(1'b1, 1'b0);
    chk(32'(switch_out), 32'h0);
    set_field(1'b0, 1'b1);
    chk(32'(switch_out), 32'h1);
    repeat (3) sofp_prog_model_i.pulse(LV_MID);
    chk(32'(fall), 32'h3);
    rd_chk(SOFP_ADDR_CONFIG, 32'h0E00, 32'h0E00);
    sofp_prog_model_i.pulse(LV_MID);
    rd_chk(SOFP_ADDR_CONFIG, 32'h0E00, 32'h0);
    $display("done: fall time and invert try");
  endtask

  // all four threshold registers; odd ids count down, ids 2 and 3 are negative
  task automatic t_th();
    for (int id = 0; id < 4; id++) begin
      reset_dut();
      sofp_prog_model_i.key(3'(id));
      chk(32'(mag), id[0] ? 32'hFE : 32'h1);
      chk(32'(sign), 32'(id[1]));
    end
    sofp_prog_model_i.pulse(LV_MID);
    chk(32'(mag), 32'hFD);
    reset_dut();
    chk(32'(mag), 32'h0);
    $display("done: threshold try");
  endtask

  task automatic t_blow();
    reset_dut();
    sofp_prog_model_i.key(3'h0);
    sofp_prog_model_i.mode(int'(SOFP_MODE_RUN));
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h3);
    sofp_prog_model_i.pulse(LV_HIGH);
    rd_chk(SOFP_ADDR_FUSE, 32'h1FFF, 32'h1);
    sofp_prog_model_i.pulse(LV_MID);
    sofp_prog_model_i.pulse(LV_HIGH);
    rd_chk(SOFP_ADDR_FUSE, 32'h1FFF, 32'h3);
    restart();
    sofp_prog_model_i.key(SOFP_ID_LOCK);
    sofp_prog_model_i.mode(int'(SOFP_MODE_RUN));
    sofp_prog_model_i.pulse(LV_HIGH);
    rd_chk(SOFP_ADDR_FUSE, 32'h1FFF, 32'h1003);
    rd_chk(SOFP_ADDR_STATUS, 32'h40, 32'h40);
    // a parameter key while locked must park the decoder
    restart();
    sofp_prog_model_i.key(3'h0);
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h5);
    // the fuse check stays open; field says off, so blown bits show as on
    restart();
    sofp_prog_model_i.key(SOFP_ID_READ);
    sofp_prog_model_i.mode(int'(SOFP_MODE_RUN));
    chk(32'(switch_out), 32'h1);
    sofp_prog_model_i.pulse(LV_MID);
    chk(32'(switch_out), 32'h1);
    sofp_prog_model_i.pulse(LV_MID);
    chk(32'(switch_out), 32'h0);
    $display("done: blow and lock");
  endtask

  // the field says on, so a blank fuse bit must pull the output low
  task automatic t_read();
    reset_dut();
    set_field(1'b1, 1'b0);
    sofp_prog_model_i.key(SOFP_ID_READ);
    sofp_prog_model_i.mode(int'(SOFP_MODE_RUN));
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h4);
    chk(32'(switch_out), 32'h0);
    $display("done: read mode");
  endtask

  task automatic t_ref();
    logic [31:0] rd;
    logic        err;
    reset_dut();
    sofp_prog_model_i.pulse(LV_MID);
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h0);
    sofp_prog_model_i.pulse(LV_HIGH, 50);
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h0);
    apb(1'b1, SOFP_ADDR_CTRL, 32'h0, rd, err);
    sofp_prog_model_i.key(3'h0);
    chk(32'(mag), 32'h0);
    reset_dut();
    sofp_prog_model_i.pulse(LV_HIGH);
    sofp_prog_model_i.pulse(LV_HIGH);
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h5);
    reset_dut();
    sofp_prog_model_i.key(3'h0);
    sofp_prog_model_i.mode(10);
    rd_chk(SOFP_ADDR_STATUS, 32'h7, 32'h5);
    $display("done: refused sequences");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    above   = 1'b0;
    below   = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_out();
    t_inv();
    t_th();
    t_blow();
    t_read();
    t_ref();
    print_verdict();
  end
endmodule
